// ### rtl/aux_cmd_pkg.sv
// What this block does
// - host sets write enable latch, then sends 42H, three address bytes, data bytes.
// - chip select rise after valid 42H starts timed program; busy flag held, latch cleared.
// - program aimed at a security register whose lock bit is 1 is ignored.
// - address: top byte zero, bits 15-13 zero, bit 12 picks register, bits 11-10 zero, low ten offset.
// - 48H, three address bytes, one dummy byte in; data out on falling edges.
// - read offset increments per byte, wraps 3FFH to 000H, runs until deselect.
// - accepted reset aborts operations and clears write enable latch, busy, suspend and sleep flags to power-on values.
// - during reset recovery every incoming command is refused.
// - suspend 75H accepted only during program or erase with suspend clear, busy set.
// - accepted suspend sets suspend flag at once, clears busy within suspend latency.
// - program suspended: status write, security erase/program, erases, page programs rejected.
// - erase suspended: status write, security erase and all erases rejected.
// - resume 7AH only when suspended and idle; flag cleared, busy within 200ns.
// - B9H must end exactly after eighth bit; sleep entered a delay after deselect.
// - asleep, only wake/ID and software reset commands are obeyed.
// - sleep command during a busy cycle is rejected, cycle undisturbed.
// - wake alone then deselect; commands refused until wake time passes.
// - ABH plus three dummy bytes shifts device ID out, MSB first, repeating.
// - wake/ID ignored while busy flag is 1, running cycle unaffected.
package aux_cmd_pkg;
	localparam int CLK_MHZ = 100;
	localparam int SUSPEND_NS = 5000;
	localparam int RESUME_NS = 200;
	localparam int SLEEP_ENTRY_NS = 3000;
	localparam int WAKE_NS = 3000;
	localparam int WAKE_ID_NS = 8000;
	localparam int RESET_NS = 30000;
	localparam int OP_CYCLES_DEF = 100000;
	localparam logic [19:0] SUSPEND_CYC = 20'(SUSPEND_NS * CLK_MHZ / 1000);
	localparam logic [19:0] RESUME_CYC = 20'(RESUME_NS * CLK_MHZ / 1000);
	localparam logic [19:0] SLEEP_CYC = 20'((SLEEP_ENTRY_NS * CLK_MHZ + 999) / 1000);
	localparam logic [19:0] WAKE_CYC = 20'((WAKE_NS * CLK_MHZ + 999) / 1000);
	localparam logic [19:0] WAKE_ID_CYC = 20'((WAKE_ID_NS * CLK_MHZ + 999) / 1000);
	localparam logic [19:0] RESET_CYC = 20'((RESET_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0] OP_WR_ENABLE = 8'h06;
	localparam logic [7:0] OP_WR_DISABLE = 8'h04;
	localparam logic [7:0] OP_STATUS_WR = 8'h01;
	localparam logic [7:0] OP_PAGE_PROG = 8'h02;
	localparam logic [7:0] OP_QUAD_PROG = 8'h32;
	localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
	localparam logic [7:0] OP_BLOCK32_ERASE = 8'h52;
	localparam logic [7:0] OP_BLOCK64_ERASE = 8'hd8;
	localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
	localparam logic [7:0] OP_CHIP_ERASE_B = 8'hc7;
	localparam logic [7:0] OP_SEC_ERASE = 8'h44;
	localparam logic [7:0] OP_SEC_PROG = 8'h42;
	localparam logic [7:0] OP_SEC_READ = 8'h48;
	localparam logic [7:0] OP_RST_ENABLE = 8'h66;
	localparam logic [7:0] OP_RESET = 8'h99;
	localparam logic [7:0] OP_SUSPEND = 8'h75;
	localparam logic [7:0] OP_RESUME = 8'h7a;
	localparam logic [7:0] OP_SLEEP = 8'hb9;
	localparam logic [7:0] OP_WAKE = 8'hab;
	localparam logic [5:0] CNT_OP = 6'h08;
	localparam logic [5:0] CNT_ADDR = 6'h20;
	localparam logic [5:0] CNT_DATA = 6'h28;
	localparam logic [5:0] CNT_SAT = 6'h29;
	localparam logic [8:0] PBUF_FULL = 9'h100;
	localparam int SEC_BANK_BIT = 12;
	// arbitrary value
	localparam logic [7:0] DEVICE_ID = 8'h3c;
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_BUSY = 7'h02,
		ST_SUSP_WAIT = 7'h04,
		ST_RES_WAIT = 7'h08,
		ST_RECOVER = 7'h10,
		ST_ENTER_SLEEP = 7'h20,
		ST_ASLEEP = 7'h40
	} state_t;
	typedef enum logic [1:0] {KIND_PROG = 2'h0, KIND_ERASE = 2'h1, KIND_SECPG = 2'h2, KIND_SECER = 2'h3} kind_t;
	typedef struct packed {
		logic [7:0] op;
		logic [5:0] cnt;
		logic [23:0] addr;
		logic [8:0] npb;
	} frame_t;
	typedef struct packed {
		frame_t f;
		logic tgl;
		logic [2:0] bitn;
		logic [7:0] sh;
		logic [9:0] rd_off;
	} link_t;
	typedef struct packed {
		state_t state;
		kind_t kind;
		kind_t susp_kind;
		logic [19:0] timer;
		logic [19:0] rem;
		logic [10:0] idx;
		logic [10:0] base;
		logic [8:0] npb;
		logic write_enable_latch;
		logic write_in_progress_flag;
		logic suspend_flag;
		logic dpd;
		logic rst_en;
		logic soft_rst;
		logic refuse;
		logic cs_s1;
		logic cs_s2;
		logic cs_s3;
		logic tg_s1;
		logic tg_s2;
		logic tg_seen;
	} core_t;
	localparam core_t CORE_RST = '{state: ST_IDLE, kind: KIND_PROG, susp_kind: KIND_PROG, cs_s1: 1'b1,
		cs_s2: 1'b1, cs_s3: 1'b1, default: '0};
endpackage

// ### rtl/aux_cmd_logic.sv
`timescale 1ns/1ps
`default_nettype none
module aux_cmd_logic #(
	parameter int OP_CYCLES = aux_cmd_pkg::OP_CYCLES_DEF
) (
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	input wire logic sclk_i,
	input wire logic cs_b_i,
	input wire logic si_i,
	input wire logic secure_area_lock_zero_i,
	input wire logic secure_area_lock_one_i,
	output logic so_o,
	output logic so_oe_b_o,
	output logic write_enable_latch_o,
	output logic write_in_progress_flag_o,
	output logic suspend_flag_o,
	output logic deep_sleep_o,
	output logic soft_reset_o
);
	localparam int SUS_BOUND = aux_cmd_pkg::SUSPEND_NS * aux_cmd_pkg::CLK_MHZ / 1000 + 2;
	localparam int RES_BOUND = aux_cmd_pkg::RESUME_NS * aux_cmd_pkg::CLK_MHZ / 1000 + 1;

	aux_cmd_pkg::core_t c;
	aux_cmd_pkg::core_t n;
	aux_cmd_pkg::link_t lk;
	aux_cmd_pkg::link_t nl;
	logic in_frame_r;
	logic frame_clr;
	logic [2:0] lsync1_r;
	logic [2:0] lsync2_r;
	logic so_r;
	logic so_oe_b_r;
	logic [7:0] sec_mem [0:2047];
	logic [7:0] pbuf [0:255];
	logic mem_we;
	logic [10:0] mem_addr;
	logic [7:0] mem_wd;
	logic pb_we;
	logic [7:0] pb_wd;
	logic fe;
	logic exact8;
	logic sec_ok;
	logic locked;
	logic blocked;
	logic idle;
	logic sleepish;
	logic rd_phase;
	logic id_phase;
	logic rd_bit;
	logic id_bit;
	logic [7:0] op;

	assign frame_clr = cs_b_i | ~rst_b_i;

	// link side: frame tracking
	always_ff @(posedge sclk_i or posedge frame_clr) begin
		if (frame_clr) begin
			in_frame_r <= 1'b0;
		end else begin
			in_frame_r <= 1'b1;
		end
	end

	// core flags into the link clock: busy, asleep, recovering
	always_ff @(posedge sclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			lsync1_r <= 3'h0;
			lsync2_r <= 3'h0;
		end else begin
			lsync1_r <= {c.write_in_progress_flag, c.dpd, c.refuse};
			lsync2_r <= lsync1_r;
		end
	end

	always_comb begin
		nl = lk;
		pb_we = 1'b0;
		pb_wd = {lk.sh[6:0], si_i};
		nl.sh = {lk.sh[6:0], si_i};
		if (!in_frame_r) begin
			nl.tgl = ~lk.tgl;
			nl.f.cnt = 6'h01;
			nl.bitn = 3'h1;
			nl.f.op = {7'h00, si_i};
			nl.f.npb = 9'h000;
		end else begin
			nl.bitn = lk.bitn + 3'h1;
			if (lk.f.cnt != aux_cmd_pkg::CNT_SAT) begin
				nl.f.cnt = lk.f.cnt + 6'h01;
			end
			if (lk.f.cnt < aux_cmd_pkg::CNT_OP) begin
				nl.f.op = {lk.f.op[6:0], si_i};
			end else if (lk.f.cnt < aux_cmd_pkg::CNT_ADDR) begin
				nl.f.addr = {lk.f.addr[22:0], si_i};
			end
			if (lk.f.cnt == aux_cmd_pkg::CNT_ADDR - 6'h01) begin
				nl.rd_off = {lk.f.addr[8:0], si_i};
			end
			if (lk.f.cnt >= aux_cmd_pkg::CNT_ADDR && nl.bitn == 3'h0) begin
				if (lk.f.op == aux_cmd_pkg::OP_SEC_PROG && !lsync2_r[2] && lk.f.npb != aux_cmd_pkg::PBUF_FULL) begin
					pb_we = 1'b1;
					nl.f.npb = lk.f.npb + 9'h001;
				end
				if (lk.f.cnt >= aux_cmd_pkg::CNT_DATA) begin
					nl.rd_off = lk.rd_off + 10'h001;
				end
			end
		end
	end

	always_ff @(posedge sclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			lk <= '0;
		end else begin
			lk <= nl;
		end
	end

	always_ff @(posedge sclk_i) begin
		if (pb_we) begin
			pbuf[lk.f.npb[7:0]] <= pb_wd;
		end
	end

	// link side: serial output on falling edges
	always_comb begin
		rd_phase = lk.f.op == aux_cmd_pkg::OP_SEC_READ && lk.f.cnt >= aux_cmd_pkg::CNT_DATA
			&& lsync2_r == 3'h0;
		id_phase = lk.f.op == aux_cmd_pkg::OP_WAKE && lk.f.cnt >= aux_cmd_pkg::CNT_ADDR
			&& !lsync2_r[2] && !lsync2_r[0];
		rd_bit = sec_mem[{lk.f.addr[aux_cmd_pkg::SEC_BANK_BIT], lk.rd_off}][3'h7 - lk.bitn];
		id_bit = aux_cmd_pkg::DEVICE_ID[3'h7 - lk.bitn];
	end

	always_ff @(negedge sclk_i or posedge frame_clr) begin
		if (frame_clr) begin
			so_r <= 1'b0;
			so_oe_b_r <= 1'b1;
		end else begin
			so_r <= rd_phase ? rd_bit : (id_phase & id_bit);
			so_oe_b_r <= ~(rd_phase | id_phase);
		end
	end

	// core side: frame decode
	always_comb begin
		op = lk.f.op;
		fe = c.cs_s2 & ~c.cs_s3 & (c.tg_s2 != c.tg_seen);
		exact8 = lk.f.cnt == aux_cmd_pkg::CNT_OP;
		sec_ok = lk.f.addr[23:13] == 11'h000 && lk.f.addr[11:10] == 2'h0;
		locked = lk.f.addr[aux_cmd_pkg::SEC_BANK_BIT] ? secure_area_lock_one_i : secure_area_lock_zero_i;
		idle = c.state == aux_cmd_pkg::ST_IDLE;
		sleepish = c.state == aux_cmd_pkg::ST_ASLEEP || c.state == aux_cmd_pkg::ST_ENTER_SLEEP;
		blocked = c.suspend_flag && (op == aux_cmd_pkg::OP_STATUS_WR || op == aux_cmd_pkg::OP_SEC_ERASE
			|| op == aux_cmd_pkg::OP_SECTOR_ERASE || op == aux_cmd_pkg::OP_BLOCK32_ERASE
			|| op == aux_cmd_pkg::OP_BLOCK64_ERASE || op == aux_cmd_pkg::OP_CHIP_ERASE_A
			|| op == aux_cmd_pkg::OP_CHIP_ERASE_B
			|| (c.susp_kind == aux_cmd_pkg::KIND_PROG && (op == aux_cmd_pkg::OP_SEC_PROG
			|| op == aux_cmd_pkg::OP_PAGE_PROG || op == aux_cmd_pkg::OP_QUAD_PROG)));
	end

	always_comb begin
		logic go;
		go = 1'b0;
		n = c;
		mem_we = 1'b0;
		mem_addr = {c.base[10], c.idx[9:0]};
		mem_wd = 8'hff;
		n.soft_rst = 1'b0;
		n.cs_s1 = cs_b_i;
		n.cs_s2 = c.cs_s1;
		n.cs_s3 = c.cs_s2;
		n.tg_s1 = lk.tgl;
		n.tg_s2 = c.tg_s1;
		if (c.timer != 20'h00000) begin
			n.timer = c.timer - 20'h00001;
		end
		case (c.state)
			aux_cmd_pkg::ST_IDLE: begin
				n.state = aux_cmd_pkg::ST_IDLE;
			end
			aux_cmd_pkg::ST_BUSY: begin
				if (c.kind == aux_cmd_pkg::KIND_SECPG && c.idx < {2'h0, c.npb}) begin
					mem_we = 1'b1;
					mem_addr = {c.base[10:8], 8'(c.base[7:0] + c.idx[7:0])};
					mem_wd = sec_mem[mem_addr] & pbuf[c.idx[7:0]];
					n.idx = c.idx + 11'h001;
				end
				if (c.kind == aux_cmd_pkg::KIND_SECER && !c.idx[10]) begin
					mem_we = 1'b1;
					n.idx = c.idx + 11'h001;
				end
				if (c.timer == 20'h00000) begin
					n.write_in_progress_flag = 1'b0;
					n.state = aux_cmd_pkg::ST_IDLE;
				end
			end
			aux_cmd_pkg::ST_SUSP_WAIT: begin
				if (c.timer == 20'h00000) begin
					n.write_in_progress_flag = 1'b0;
					n.state = aux_cmd_pkg::ST_IDLE;
				end
			end
			aux_cmd_pkg::ST_RES_WAIT: begin
				if (c.timer == 20'h00000) begin
					n.write_in_progress_flag = 1'b1;
					n.timer = c.rem;
					n.kind = c.susp_kind;
					n.state = aux_cmd_pkg::ST_BUSY;
				end
			end
			aux_cmd_pkg::ST_RECOVER: begin
				if (c.timer == 20'h00000) begin
					n.state = aux_cmd_pkg::ST_IDLE;
				end
			end
			aux_cmd_pkg::ST_ENTER_SLEEP: begin
				if (c.timer == 20'h00000) begin
					n.dpd = 1'b1;
					n.state = aux_cmd_pkg::ST_ASLEEP;
				end
			end
			aux_cmd_pkg::ST_ASLEEP: begin
				n.state = aux_cmd_pkg::ST_ASLEEP;
			end
			default: begin
				n.state = aux_cmd_pkg::ST_IDLE;
			end
		endcase
		if (fe) begin
			n.tg_seen = c.tg_s2;
			if (c.state != aux_cmd_pkg::ST_RECOVER) begin
				n.rst_en = op == aux_cmd_pkg::OP_RST_ENABLE && exact8;
				case (op)
					aux_cmd_pkg::OP_RESET: begin
						if (exact8 && c.rst_en) begin
							n.write_enable_latch = 1'b0;
							n.write_in_progress_flag = 1'b0;
							n.suspend_flag = 1'b0;
							n.dpd = 1'b0;
							n.soft_rst = 1'b1;
							n.timer = aux_cmd_pkg::RESET_CYC;
							n.state = aux_cmd_pkg::ST_RECOVER;
						end
					end
					aux_cmd_pkg::OP_WAKE: begin
						if (sleepish) begin
							n.dpd = 1'b0;
							n.timer = exact8 ? aux_cmd_pkg::WAKE_CYC : aux_cmd_pkg::WAKE_ID_CYC;
							n.state = aux_cmd_pkg::ST_RECOVER;
						end
					end
					aux_cmd_pkg::OP_SUSPEND: begin
						if (exact8 && c.state == aux_cmd_pkg::ST_BUSY && !c.suspend_flag
							&& (c.kind == aux_cmd_pkg::KIND_PROG || c.kind == aux_cmd_pkg::KIND_ERASE)) begin
							n.suspend_flag = 1'b1;
							n.rem = c.timer;
							n.susp_kind = c.kind;
							n.timer = aux_cmd_pkg::SUSPEND_CYC;
							n.state = aux_cmd_pkg::ST_SUSP_WAIT;
						end
					end
					aux_cmd_pkg::OP_RESUME: begin
						if (exact8 && idle && c.suspend_flag) begin
							n.suspend_flag = 1'b0;
							n.timer = aux_cmd_pkg::RESUME_CYC;
							n.state = aux_cmd_pkg::ST_RES_WAIT;
						end
					end
					aux_cmd_pkg::OP_SLEEP: begin
						if (exact8 && idle) begin
							n.timer = aux_cmd_pkg::SLEEP_CYC;
							n.state = aux_cmd_pkg::ST_ENTER_SLEEP;
						end
					end
					aux_cmd_pkg::OP_WR_ENABLE: begin
						if (exact8 && idle) begin
							n.write_enable_latch = 1'b1;
						end
					end
					aux_cmd_pkg::OP_WR_DISABLE: begin
						if (exact8 && idle) begin
							n.write_enable_latch = 1'b0;
						end
					end
					aux_cmd_pkg::OP_PAGE_PROG, aux_cmd_pkg::OP_QUAD_PROG: begin
						go = idle && c.write_enable_latch && !blocked && lk.f.cnt >= aux_cmd_pkg::CNT_DATA;
						n.kind = go ? aux_cmd_pkg::KIND_PROG : c.kind;
					end
					aux_cmd_pkg::OP_SECTOR_ERASE, aux_cmd_pkg::OP_BLOCK32_ERASE, aux_cmd_pkg::OP_BLOCK64_ERASE: begin
						go = idle && c.write_enable_latch && !blocked && lk.f.cnt == aux_cmd_pkg::CNT_ADDR;
						n.kind = go ? aux_cmd_pkg::KIND_ERASE : c.kind;
					end
					aux_cmd_pkg::OP_CHIP_ERASE_A, aux_cmd_pkg::OP_CHIP_ERASE_B: begin
						go = idle && c.write_enable_latch && !blocked && exact8;
						n.kind = go ? aux_cmd_pkg::KIND_ERASE : c.kind;
					end
					aux_cmd_pkg::OP_SEC_PROG: begin
						go = idle && c.write_enable_latch && !blocked && sec_ok && !locked
							&& lk.f.cnt >= aux_cmd_pkg::CNT_DATA && lk.f.npb != 9'h000;
						n.kind = go ? aux_cmd_pkg::KIND_SECPG : c.kind;
					end
					aux_cmd_pkg::OP_SEC_ERASE: begin
						go = idle && c.write_enable_latch && !blocked && sec_ok && !locked
							&& lk.f.cnt == aux_cmd_pkg::CNT_ADDR;
						n.kind = go ? aux_cmd_pkg::KIND_SECER : c.kind;
					end
					default: begin
						go = 1'b0;
					end
				endcase
				if (go) begin
					n.write_enable_latch = 1'b0;
					n.write_in_progress_flag = 1'b1;
					n.idx = 11'h000;
					n.base = {lk.f.addr[aux_cmd_pkg::SEC_BANK_BIT], lk.f.addr[9:0]};
					n.npb = lk.f.npb;
					n.timer = 20'(OP_CYCLES);
					n.state = aux_cmd_pkg::ST_BUSY;
				end
			end
		end
		n.refuse = n.state == aux_cmd_pkg::ST_RECOVER;
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			c <= aux_cmd_pkg::CORE_RST;
		end else begin
			c <= n;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (mem_we) begin
			sec_mem[mem_addr] <= mem_wd;
		end
	end

	assign so_o = so_r;
	assign so_oe_b_o = so_oe_b_r;
	assign write_enable_latch_o = c.write_enable_latch;
	assign write_in_progress_flag_o = c.write_in_progress_flag;
	assign suspend_flag_o = c.suspend_flag;
	assign deep_sleep_o = c.dpd;
	assign soft_reset_o = c.soft_rst;

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_b_i);

	chk_sus_set_now: assert property (
		(fe && op == aux_cmd_pkg::OP_SUSPEND && exact8 && c.state == aux_cmd_pkg::ST_BUSY && !c.suspend_flag
			&& c.kind inside {aux_cmd_pkg::KIND_PROG, aux_cmd_pkg::KIND_ERASE}) |=> c.suspend_flag && c.write_in_progress_flag)
		else $error("suspend not flagged at once");
	chk_sus_wip_drop: assert property (
		$rose(c.suspend_flag) |-> ##[1:SUS_BOUND] !c.write_in_progress_flag)
		else $error("busy not cleared within suspend latency");
	chk_resume_wip: assert property (
		($fell(c.suspend_flag) && !c.soft_rst) |-> !c.write_in_progress_flag ##[1:RES_BOUND] c.write_in_progress_flag)
		else $error("busy not raised after resume");
	chk_lock_write: assert property (
		(mem_we && c.kind == aux_cmd_pkg::KIND_SECPG && $stable(secure_area_lock_zero_i)) |->
			!(c.base[10] ? secure_area_lock_one_i : secure_area_lock_zero_i))
		else $error("locked security register written");
	chk_wel_cleared: assert property (
		($rose(c.write_in_progress_flag) && c.state == aux_cmd_pkg::ST_BUSY && $past(c.state) == aux_cmd_pkg::ST_IDLE) |-> !c.write_enable_latch)
		else $error("write enable latch kept after start");
	chk_recover_refuse: assert property (
		(c.state == aux_cmd_pkg::ST_RECOVER && fe) |=> $stable(c.write_enable_latch) && !c.write_in_progress_flag && !c.rst_en)
		else $error("command taken during recovery");
	chk_sleep_ignore: assert property (
		(c.state == aux_cmd_pkg::ST_ASLEEP && fe && op != aux_cmd_pkg::OP_WAKE && op != aux_cmd_pkg::OP_RESET)
			|=> c.state == aux_cmd_pkg::ST_ASLEEP && c.dpd)
		else $error("asleep device obeyed a command");
	chk_wake_busy: assert property (
		(fe && op == aux_cmd_pkg::OP_WAKE && c.state == aux_cmd_pkg::ST_BUSY && c.timer > 20'h00001)
			|=> c.state == aux_cmd_pkg::ST_BUSY && c.write_in_progress_flag)
		else $error("wake disturbed busy cycle");
	chk_sleep_busy: assert property (
		(fe && op == aux_cmd_pkg::OP_SLEEP && c.write_in_progress_flag) |=> c.state != aux_cmd_pkg::ST_ENTER_SLEEP)
		else $error("sleep accepted while busy");
	chk_reset_clears: assert property (
		(fe && op == aux_cmd_pkg::OP_RESET && exact8 && c.rst_en && c.state != aux_cmd_pkg::ST_RECOVER)
			|=> c.state == aux_cmd_pkg::ST_RECOVER && !c.write_enable_latch && !c.suspend_flag && !c.dpd && c.soft_rst)
		else $error("reset did not restore power-on state");
	chk_rst_en_cancel: assert property (
		(fe && op != aux_cmd_pkg::OP_RST_ENABLE) |=> !c.rst_en)
		else $error("reset enable survived another frame");
endmodule
`default_nettype wire

// ### testbench/spi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
	input wire logic ref_clk_i,
	input wire logic so_i,
	output logic sclk_o,
	output logic cs_b_o,
	output logic si_o
);
	initial begin
		sclk_o = 1'b0;
		cs_b_o = 1'b1;
		si_o = 1'b0;
	end
	// select just after a core edge; link clock idles low between frames
	task automatic sel();
		@(posedge ref_clk_i);
		#1 cs_b_o = 1'b0;
		#6;
	endtask
	// one byte out msb first, reply sampled on each rising link edge
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			si_o = tx[i];
			#6 sclk_o = 1'b1;
			rx[i] = so_i;
			#6 sclk_o = 1'b0;
		end
	endtask
	// deselect; data line flips so a stale bit never looks valid
	task automatic desel(input int gap);
		#6 cs_b_o = 1'b1;
		si_o = ~si_o;
		repeat (gap) @(posedge ref_clk_i);
		#1;
	endtask
endmodule
`default_nettype wire

// ### testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam int OPC = 1200;
	logic ref_clk, rst_b, lock0, lock1, sclk, cs_b, si, so, so_oe_b, write_enable_latch, write_in_progress_flag, suspend_flag, dsl, srst;
	int error_cnt, tests_run, srst_cnt;
	aux_cmd_logic #(.OP_CYCLES(OPC)) aux_cmd_logic_inst (.ref_clk_i(ref_clk), .rst_b_i(rst_b), .sclk_i(sclk),
		.cs_b_i(cs_b), .si_i(si), .secure_area_lock_zero_i(lock0), .secure_area_lock_one_i(lock1), .so_o(so),
		.so_oe_b_o(so_oe_b), .write_enable_latch_o(write_enable_latch), .write_in_progress_flag_o(write_in_progress_flag), .suspend_flag_o(suspend_flag),
		.deep_sleep_o(dsl), .soft_reset_o(srst));
	spi_host_model spi_host_model_inst (.ref_clk_i(ref_clk), .so_i(so), .sclk_o(sclk), .cs_b_o(cs_b), .si_o(si));
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	always @(negedge ref_clk) if (srst === 1'b1) srst_cnt++;
	function automatic logic flag(input int s);
		case (s)
			0: return write_enable_latch;
			1: return write_in_progress_flag;
			2: return suspend_flag;
			default: return dsl;
		endcase
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	// wait up to hi cycles for a flag, no sooner than lo cycles
	task automatic fl(input int s, input logic v, input int lo, input int hi, input string what);
		int n;
		n = 0;
		while (flag(s) !== v && n < hi) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		chk({7'h0, flag(s)}, {7'h0, v}, what);
		if (lo > 0) chk({7'h0, n >= lo}, 8'h01, what);
	endtask
	task automatic idle(input int c);
		repeat (c) @(posedge ref_clk);
		#1;
	endtask
	task automatic cmd(input logic [7:0] q[$], input int gap = 10);
		logic [7:0] r;
		spi_host_model_inst.sel();
		foreach (q[i]) spi_host_model_inst.xfer(q[i], r);
		spi_host_model_inst.desel(gap);
	endtask
	task automatic rd(input logic [7:0] h[$], input logic [7:0] e[$], input string what);
		logic [7:0] r;
		spi_host_model_inst.sel();
		foreach (h[i]) spi_host_model_inst.xfer(h[i], r);
		foreach (e[i]) begin
			spi_host_model_inst.xfer(8'h00, r);
			chk(r, e[i], what);
		end
		chk({7'h0, so_oe_b}, 8'h00, what);
		spi_host_model_inst.desel(10);
		chk({7'h0, so_oe_b}, 8'h01, what);
	endtask
	task automatic t_power_on();
		for (int s = 0; s < 4; s++) fl(s, 1'b0, 0, 0, "power-on flag");
		chk({7'h0, so_oe_b}, 8'h01, "power-on output enable");
		$display("done power_on");
	endtask
	task automatic t_secure();
		cmd('{8'h06});
		fl(0, 1'b1, 0, 0, "latch set");
		cmd('{8'h44, 8'h00, 8'h00, 8'h00}, 0);
		fl(1, 1'b1, 0, 10, "erase busy");
		fl(1, 1'b0, OPC - 5, OPC + 20, "erase done");
		cmd('{8'h06});
		cmd('{8'h42, 8'h00, 8'h03, 8'hfe, 8'ha5, 8'h5a}, 0);
		fl(1, 1'b1, 0, 10, "program busy");
		fl(0, 1'b0, 0, 0, "latch cleared");
		fl(1, 1'b0, OPC - 5, OPC + 20, "program done");
		rd('{8'h48, 8'h00, 8'h03, 8'hfe, 8'h00}, '{8'ha5, 8'h5a, 8'hff, 8'hff}, "secure read wrap");
		lock0 = 1'b1;
		cmd('{8'h06});
		cmd('{8'h42, 8'h00, 8'h00, 8'h10, 8'h00}, 20);
		fl(1, 1'b0, 0, 0, "locked program ignored");
		cmd('{8'h42, 8'h00, 8'h14, 8'h00, 8'h00}, 20);
		fl(1, 1'b0, 0, 0, "bad address ignored");
		cmd('{8'h42, 8'h00, 8'h10, 8'h00, 8'h0f}, 0);
		fl(1, 1'b1, 0, 10, "register one program");
		fl(1, 1'b0, 0, OPC + 20, "register one done");
		lock0 = 1'b0;
		$display("done secure");
	endtask
	task automatic t_suspend();
		cmd('{8'h75}, 20);
		fl(2, 1'b0, 0, 0, "idle suspend ignored");
		cmd('{8'h06});
		cmd('{8'h20, 8'h00, 8'h00, 8'h00}, 0);
		fl(1, 1'b1, 0, 10, "erase busy");
		cmd('{8'hb9}, 330);
		fl(3, 1'b0, 0, 0, "sleep while busy rejected");
		cmd('{8'hab, 8'h00, 8'h00, 8'h00}, 20);
		fl(1, 1'b1, 0, 0, "wake while busy ignored");
		cmd('{8'h75}, 0);
		fl(2, 1'b1, 0, 10, "suspend flag");
		fl(1, 1'b0, 0, 520, "suspend busy drop");
		cmd('{8'h06});
		cmd('{8'h44, 8'h00, 8'h00, 8'h00}, 20);
		fl(1, 1'b0, 0, 0, "erase suspended refusal");
		cmd('{8'h60}, 20);
		fl(1, 1'b0, 0, 0, "chip erase suspended refusal");
		cmd('{8'h7a}, 0);
		fl(2, 1'b0, 0, 10, "resume flag");
		fl(1, 1'b1, 0, 30, "resume busy");
		fl(1, 1'b0, 0, OPC + 20, "resumed erase done");
		cmd('{8'h7a}, 30);
		fl(1, 1'b0, 0, 0, "idle resume ignored");
		cmd('{8'h06});
		cmd('{8'h02, 8'h00, 8'h00, 8'h00, 8'h11}, 0);
		fl(1, 1'b1, 0, 10, "page program busy");
		cmd('{8'h75}, 0);
		fl(1, 1'b0, 0, 520, "program suspended");
		cmd('{8'h06});
		cmd('{8'h42, 8'h00, 8'h00, 8'h00, 8'h00}, 20);
		fl(1, 1'b0, 0, 0, "program suspended refusal");
		cmd('{8'h32, 8'h00, 8'h00, 8'h00, 8'h00}, 20);
		fl(1, 1'b0, 0, 0, "quad program suspended refusal");
		cmd('{8'h7a}, 0);
		fl(1, 1'b1, 0, 30, "program resumed");
		fl(1, 1'b0, 0, OPC + 20, "program done");
		$display("done suspend");
	endtask
	task automatic t_sleep();
		cmd('{8'h04});
		cmd('{8'hb9, 8'h00}, 330);
		fl(3, 1'b0, 0, 0, "long sleep frame discarded");
		cmd('{8'hb9}, 0);
		fl(3, 1'b1, 250, 320, "sleep entered");
		cmd('{8'h06});
		fl(0, 1'b0, 0, 0, "asleep write refused");
		cmd('{8'hab}, 0);
		fl(3, 1'b0, 0, 10, "woken");
		cmd('{8'h06});
		fl(0, 1'b0, 0, 0, "wake time refusal");
		idle(310);
		cmd('{8'h06});
		fl(0, 1'b1, 0, 0, "after wake time");
		rd('{8'hab, 8'h00, 8'h00, 8'h00}, '{8'h3c, 8'h3c}, "device id");
		cmd('{8'h04});
		cmd('{8'hb9}, 330);
		fl(3, 1'b1, 0, 0, "asleep again");
		rd('{8'hab, 8'h00, 8'h00, 8'h00}, '{8'h3c}, "id while asleep");
		fl(3, 1'b0, 0, 10, "woken by id form");
		idle(310);
		cmd('{8'h06});
		fl(0, 1'b0, 0, 0, "long wake refusal");
		idle(500);
		cmd('{8'h06});
		fl(0, 1'b1, 0, 0, "after long wake");
		$display("done sleep");
	endtask
	task automatic t_reset();
		int c0;
		c0 = srst_cnt;
		cmd('{8'h66});
		cmd('{8'h75});
		cmd('{8'h99});
		chk(8'(srst_cnt - c0), 8'h00, "interrupted reset pair");
		fl(0, 1'b1, 0, 0, "latch kept");
		fl(1, 1'b0, 0, 0, "idle before reset");
		fl(2, 1'b0, 0, 0, "not suspended before reset");
		cmd('{8'h66});
		cmd('{8'h99}, 10);
		chk(8'(srst_cnt - c0), 8'h01, "reset pulse");
		fl(0, 1'b0, 0, 0, "reset clears latch");
		cmd('{8'h06});
		fl(0, 1'b0, 0, 0, "recovery refusal");
		idle(3000);
		cmd('{8'h06});
		fl(0, 1'b1, 0, 0, "after recovery");
		$display("done reset");
	endtask
	task automatic conclude();
		$display("compared %0d, bad %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		repeat (60000) @(posedge ref_clk);
		error_cnt++;
		$display("BAD %0t watchdog expired", $time);
		conclude();
	end
	initial begin
		rst_b = 1'b0;
		lock0 = 1'b0;
		lock1 = 1'b0;
		error_cnt = 0;
		tests_run = 0;
		srst_cnt = 0;
		repeat (2) @(posedge ref_clk);
		#1 rst_b = 1'b1;
		idle(5);
		t_power_on();
		t_secure();
		t_suspend();
		t_sleep();
		t_reset();
		conclude();
	end
endmodule
`default_nettype wire
